// file: rtl/sdx_params.svh
`ifndef SDX_PARAMS_SVH
`define SDX_PARAMS_SVH

// Datapath widths
`define SDX_DATA_W      16
`define SDX_ADDR_W      8

// Reset values
`define SDX_ACC_RST     16'h0000
`define SDX_PTR_RST     8'h00
`define SDX_FLAGS_RST   4'h0

// Flag vector bit positions
`define SDX_FLG_EX      3
`define SDX_FLG_L       2
`define SDX_FLG_Z       1
`define SDX_FLG_N       0

// Opcode group patterns
`define SDX_OP_MACA     2'b00
`define SDX_OP_MACS     2'b01
`define SDX_OP_LDADC    4'h8
`define SDX_OP_WR       4'h9
`define SDX_OP_ADD      4'ha
`define SDX_OP_SUB      4'hb
`define SDX_OP_PRE      3'b110
`define SDX_OP_CHG      3'b111
`define SDX_OP_DAC      8'he0

// Single pointer update codes
`define SDX_P_HOLD      2'b00
`define SDX_P_INC       2'b01
`define SDX_P_DECL      2'b10
`define SDX_P_TOP       2'b11

// Condition field codes
`define SDX_COND_ILL    2'b00
`define SDX_COND_ALWAYS 2'b01
`define SDX_COND_EX     2'b10
`define SDX_COND_N      2'b11

// Accumulator change operations
`define SDX_CHG_RRT     3'b000
`define SDX_CHG_RLT     3'b001
`define SDX_CHG_ASR     3'b010
`define SDX_CHG_ASL     3'b011
`define SDX_CHG_INC     3'b100
`define SDX_CHG_DEC     3'b101
`define SDX_CHG_NEG     3'b110
`define SDX_CHG_ABS     3'b111

`endif

// file: rtl/sdx_pkg.sv
package sdx_pkg;

    // Pointer post-modify action
    typedef enum logic [1:0] {
        SDX_STEP_HOLD = 2'b00,
        SDX_STEP_INC  = 2'b01,
        SDX_STEP_DECL = 2'b10,
        SDX_STEP_INCL = 2'b11
    } sdx_step_e;

    // Decoded instruction class
    typedef enum logic [3:0] {
        SDX_CLS_NOP   = 4'h0,
        SDX_CLS_LDADC = 4'h1,
        SDX_CLS_WR    = 4'h2,
        SDX_CLS_DAC   = 4'h3,
        SDX_CLS_ADD   = 4'h4,
        SDX_CLS_SUB   = 4'h5,
        SDX_CLS_PRE   = 4'h6,
        SDX_CLS_MACA  = 4'h7,
        SDX_CLS_MACS  = 4'h8,
        SDX_CLS_CHG   = 4'h9
    } sdx_cls_e;

endpackage

// file: rtl/sdx_ptr_step.sv
`timescale 1ns/1ps
// Next value of one data RAM pointer after its post-modify
module sdx_ptr_step
    import sdx_pkg::*;
#(
    parameter int AW = 8
) (
    // Current pointer and action
    input  wire logic [AW-1:0] ptr_cur,
    input  wire sdx_step_e     step,
    // Loop window: ones mark the bits that wrap
    input  wire logic [AW-1:0] loop_mask,
    // Result
    output logic      [AW-1:0] ptr_next
);

    localparam logic [AW-1:0] ONE = {{(AW-1){1'b0}}, 1'b1}; // Unit step

    logic [AW-1:0] ptr_up; // Plain increment
    logic [AW-1:0] ptr_dn; // Plain decrement

    assign ptr_up = ptr_cur + ONE;
    assign ptr_dn = ptr_cur - ONE;

    // Loop forms keep the bits above the window fixed
    always_comb begin
        case (step)
            SDX_STEP_HOLD: ptr_next = ptr_cur;
            SDX_STEP_INC:  ptr_next = ptr_up;
            SDX_STEP_DECL: ptr_next = (ptr_cur & ~loop_mask) | (ptr_dn & loop_mask);
            SDX_STEP_INCL: ptr_next = (ptr_cur & ~loop_mask) | (ptr_up & loop_mask);
            default:       ptr_next = ptr_cur;
        endcase
    end

endmodule // sdx_ptr_step

// file: rtl/sdx_dsp_exec.sv
`timescale 1ns/1ps
`include "sdx_params.svh"
// Operation
// - Converter result into RAM, one cycle
// - Converter result register is never written
// - Accumulator stored to RAM, one cycle
// - Opcode bits 3:2 pick the single pointer
// - Each RAM bank has its own pointer pair
// - Store update: hold, inc, dec loop, illegal
// - Add/sub code 11 means increment loop
// - Accumulator copied to analog output register
// - Analog output register is write only
// - Add RAM word, update four flags
// - Subtract RAM word, update four flags
// - Preload both operands, clear accumulator
// - Preload bits 4 and 3 pick pointers
// - Three-bit preload pointer update table
// - Add product, reload operands, update pointers
// - Subtract product, reload operands, update pointers
// - Multiply bits 2,5 select; 1:0,4:3 update
// - Conditional accumulator change, eight operations
// - Condition field and flag update
// - Rotates pass through the link bit
module sdx_dsp_exec
    import sdx_pkg::*;
#(
    parameter int DW = `SDX_DATA_W,
    parameter int AW = `SDX_ADDR_W
) (
    // Clock and reset
    input  wire logic          clk_sys,
    input  wire logic          nrst,
    // Instruction stream
    input  wire logic          instr_valid,
    input  wire logic [7:0]    instr_byte,
    // Pointer preset port
    input  wire logic          ptr_load,
    input  wire logic [1:0]    ptr_load_sel,
    input  wire logic [AW-1:0] ptr_load_value,
    // Loop windows per bank
    input  wire logic [AW-1:0] ram0_loop_mask,
    input  wire logic [AW-1:0] ram1_loop_mask,
    // Converter registers
    input  wire logic [DW-1:0] adc_result,
    output logic      [DW-1:0] dac_data,
    output logic               dac_wr,
    // Data RAM bank 0
    output logic      [AW-1:0] ram0_addr,
    input  wire logic [DW-1:0] ram0_rdata,
    output logic               ram0_we,
    output logic      [DW-1:0] ram0_wdata,
    // Data RAM bank 1
    output logic      [AW-1:0] ram1_addr,
    input  wire logic [DW-1:0] ram1_rdata,
    output logic               ram1_we,
    output logic      [DW-1:0] ram1_wdata,
    // Datapath state
    output logic      [DW-1:0] acc,
    output logic      [3:0]    flags,
    output logic      [DW-1:0] mul_a,
    output logic      [DW-1:0] mul_b,
    output logic      [AW-1:0] ram0_ptr_a,
    output logic      [AW-1:0] ram0_ptr_b,
    output logic      [AW-1:0] ram1_ptr_a,
    output logic      [AW-1:0] ram1_ptr_b,
    output logic               illegal_op
);

    // Decoding
    sdx_cls_e          cls;          // Class of the current byte
    logic              legal;        // Encoding allowed
    logic              run;          // Instruction takes effect
    logic              cond_met;     // Change condition holds
    logic [1:0]        sel0;         // Pointer index serving bank 0
    logic [1:0]        sel1;         // Pointer index serving bank 1
    logic [DW-1:0]     opnd;         // Single RAM operand
    // Pointer file
    logic [AW-1:0]     ptr_q  [4];   // Pointers 0,1 bank 0; 2,3 bank 1
    logic [AW-1:0]     ptr_nx [4];   // Stepped values
    sdx_step_e         step   [4];   // Action per pointer
    // Arithmetic
    logic [2*DW-1:0]   prod;         // Full signed product
    logic [DW-1:0]     prod_q;       // Fractional product word
    logic [DW-1:0]     rhs;          // Second adder input
    logic              do_sub;       // Adder subtracts
    logic [DW:0]       sum;          // Adder result with carry
    logic [DW-1:0]     next_acc;     // Accumulator next value
    logic [3:0]        next_flags;   // Flags next value
    logic              acc_we;       // Accumulator load
    logic              flags_we;     // Flag load
    logic              mul_we;       // Operand reload

    // Group decode of one instruction byte
    function automatic sdx_cls_e decode_cls(input logic [7:0] op);
        if (op == `SDX_OP_DAC)
            return SDX_CLS_DAC;
        else if (op[7:6] == `SDX_OP_MACA)
            return SDX_CLS_MACA;
        else if (op[7:6] == `SDX_OP_MACS)
            return SDX_CLS_MACS;
        else if (op[7:4] == `SDX_OP_LDADC)
            return SDX_CLS_LDADC;
        else if (op[7:4] == `SDX_OP_WR)
            return SDX_CLS_WR;
        else if (op[7:4] == `SDX_OP_ADD)
            return SDX_CLS_ADD;
        else if (op[7:4] == `SDX_OP_SUB)
            return SDX_CLS_SUB;
        else if (op[7:5] == `SDX_OP_PRE)
            return SDX_CLS_PRE;
        else
            return SDX_CLS_CHG;
    endfunction

    // Two-bit update code of the single pointer forms
    function automatic sdx_step_e single_step(input logic [1:0] p, input logic top_loops);
        case (p)
            `SDX_P_HOLD: return SDX_STEP_HOLD;
            `SDX_P_INC:  return SDX_STEP_INC;
            `SDX_P_DECL: return SDX_STEP_DECL;
            default:     return top_loops ? SDX_STEP_INCL : SDX_STEP_HOLD;
        endcase
    endfunction

    // Flags of a result word, overflow and link given
    function automatic logic [3:0] make_flags(input logic [DW-1:0] r, input logic ov, input logic lk);
        logic [3:0] f;
        f = 4'h0;
        f[`SDX_FLG_EX] = ov;
        f[`SDX_FLG_L]  = lk;
        f[`SDX_FLG_Z]  = (r == '0);
        f[`SDX_FLG_N]  = r[DW-1];
        return f;
    endfunction

    // Class, legality and condition
    always_comb begin
        cls      = decode_cls(instr_byte);
        legal    = 1'b1;
        cond_met = 1'b1;
        case (cls)
            SDX_CLS_LDADC: legal = (instr_byte[1:0] == `SDX_P_HOLD);
            SDX_CLS_WR:    legal = (instr_byte[1:0] != `SDX_P_TOP);
            SDX_CLS_CHG: begin
                legal = (instr_byte[4:3] != `SDX_COND_ILL);
                case (instr_byte[4:3])
                    `SDX_COND_EX: cond_met = flags[`SDX_FLG_EX];
                    `SDX_COND_N:  cond_met = flags[`SDX_FLG_N];
                    default:      cond_met = 1'b1;
                endcase
            end
            default:       legal = 1'b1;
        endcase
    end

    assign run = instr_valid & legal & cond_met;

    // Pointer selection: bank 0 from 0/1, bank 1 from 2/3
    always_comb begin
        case (cls)
            SDX_CLS_PRE: begin
                sel0 = {1'b0, instr_byte[4]};
                sel1 = {1'b1, instr_byte[3]};
            end
            SDX_CLS_MACA, SDX_CLS_MACS: begin
                sel0 = {1'b0, instr_byte[2]};
                sel1 = {1'b1, instr_byte[5]};
            end
            default: begin
                sel0 = {1'b0, instr_byte[2]};
                sel1 = {1'b1, instr_byte[2]};
            end
        endcase
    end

    // RAM addresses follow the selected pointers
    assign ram0_addr = ptr_q[sel0];
    assign ram1_addr = ptr_q[sel1];

    // Bit 3 is the bank of the single pointer forms
    assign opnd = instr_byte[3] ? ram1_rdata : ram0_rdata;

    // RAM write: accumulator or converter result
    always_comb begin
        ram0_we    = 1'b0;
        ram1_we    = 1'b0;
        ram0_wdata = acc;
        ram1_wdata = acc;
        if (run && (cls == SDX_CLS_WR || cls == SDX_CLS_LDADC)) begin
            ram0_we = ~instr_byte[3];
            ram1_we = instr_byte[3];
            if (cls == SDX_CLS_LDADC) begin
                ram0_wdata = adc_result;
                ram1_wdata = adc_result;
            end
        end
    end

    // Pointer actions for this instruction
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            step[i] = SDX_STEP_HOLD;
        end
        if (run) begin
            case (cls)
                SDX_CLS_WR: step[{instr_byte[3], instr_byte[2]}] = single_step(instr_byte[1:0], 1'b0);
                SDX_CLS_ADD, SDX_CLS_SUB: begin
                    step[{instr_byte[3], instr_byte[2]}] = single_step(instr_byte[1:0], 1'b1);
                end
                SDX_CLS_PRE: begin
                    case (instr_byte[2:0])
                        3'b000: begin step[sel0] = SDX_STEP_HOLD; step[sel1] = SDX_STEP_INC;  end
                        3'b001: begin step[sel0] = SDX_STEP_HOLD; step[sel1] = SDX_STEP_DECL; end
                        3'b010: begin step[sel0] = SDX_STEP_INC;  step[sel1] = SDX_STEP_HOLD; end
                        3'b011: begin step[sel0] = SDX_STEP_INC;  step[sel1] = SDX_STEP_INC;  end
                        3'b100: begin step[sel0] = SDX_STEP_INC;  step[sel1] = SDX_STEP_DECL; end
                        3'b101: begin step[sel0] = SDX_STEP_DECL; step[sel1] = SDX_STEP_HOLD; end
                        3'b110: begin step[sel0] = SDX_STEP_DECL; step[sel1] = SDX_STEP_INC;  end
                        default: begin step[sel0] = SDX_STEP_DECL; step[sel1] = SDX_STEP_DECL; end
                    endcase
                end
                SDX_CLS_MACA, SDX_CLS_MACS: begin
                    step[sel0] = sdx_step_e'(instr_byte[1:0]);
                    step[sel1] = sdx_step_e'(instr_byte[4:3]);
                end
                default: step[0] = SDX_STEP_HOLD;
            endcase
        end
    end

    // Pointer file with post-modify after the access
    generate
        for (genvar g = 0; g < 4; g++) begin : g_ptr
            sdx_ptr_step #(
                .AW(AW)
            ) u_step (
                .ptr_cur  (ptr_q[g]),
                .step     (step[g]),
                .loop_mask(g < 2 ? ram0_loop_mask : ram1_loop_mask),
                .ptr_next (ptr_nx[g])
            );

            // Preset port wins over an instruction update
            always_ff @(posedge clk_sys or negedge nrst) begin
                if (!nrst) begin
                    ptr_q[g] <= AW'(`SDX_PTR_RST);
                end else if (ptr_load && ptr_load_sel == 2'(g)) begin
                    ptr_q[g] <= ptr_load_value;
                end else begin
                    ptr_q[g] <= ptr_nx[g];
                end
            end
        end
    endgenerate

    assign ram0_ptr_a = ptr_q[0];
    assign ram0_ptr_b = ptr_q[1];
    assign ram1_ptr_a = ptr_q[2];
    assign ram1_ptr_b = ptr_q[3];

    // Signed multiplier, product taken as a fraction
    assign prod   = $signed(mul_a) * $signed(mul_b);
    assign prod_q = prod[2*DW-2 -: DW];

    // Shared adder for add, subtract and accumulate
    always_comb begin
        rhs    = opnd;
        do_sub = 1'b0;
        case (cls)
            SDX_CLS_SUB:  do_sub = 1'b1;
            SDX_CLS_MACA: rhs    = prod_q;
            SDX_CLS_MACS: begin
                rhs    = prod_q;
                do_sub = 1'b1;
            end
            default:      do_sub = 1'b0;
        endcase
        if (do_sub)
            sum = {1'b0, acc} - {1'b0, rhs};
        else
            sum = {1'b0, acc} + {1'b0, rhs};
    end

    // Accumulator and flag results
    always_comb begin
        next_acc   = acc;
        next_flags = flags;
        acc_we     = 1'b0;
        flags_we   = 1'b0;
        mul_we     = 1'b0;
        if (run) begin
            case (cls)
                SDX_CLS_ADD, SDX_CLS_SUB, SDX_CLS_MACA, SDX_CLS_MACS: begin
                    acc_we     = 1'b1;
                    flags_we   = 1'b1;
                    next_acc   = sum[DW-1:0];
                    next_flags = make_flags(sum[DW-1:0],
                        (acc[DW-1] ^ rhs[DW-1] ^ ~do_sub) & (sum[DW-1] ^ acc[DW-1]), sum[DW]);
                    mul_we     = (cls == SDX_CLS_MACA) || (cls == SDX_CLS_MACS);
                end
                SDX_CLS_PRE: begin
                    acc_we   = 1'b1;
                    next_acc = DW'(`SDX_ACC_RST);
                    mul_we   = 1'b1;
                end
                SDX_CLS_CHG: begin
                    acc_we   = 1'b1;
                    flags_we = 1'b1;
                    case (instr_byte[2:0])
                        `SDX_CHG_RRT: begin
                            next_acc   = {flags[`SDX_FLG_L], acc[DW-1:1]};
                            next_flags = make_flags(next_acc, 1'b0, acc[0]);
                        end
                        `SDX_CHG_RLT: begin
                            next_acc   = {acc[DW-2:0], flags[`SDX_FLG_L]};
                            next_flags = make_flags(next_acc, 1'b0, acc[DW-1]);
                        end
                        `SDX_CHG_ASR: begin
                            next_acc   = {acc[DW-1], acc[DW-1:1]};
                            next_flags = make_flags(next_acc, 1'b0, flags[`SDX_FLG_L]);
                        end
                        `SDX_CHG_ASL: begin
                            next_acc   = {acc[DW-2:0], 1'b0};
                            next_flags = make_flags(next_acc, acc[DW-1] ^ acc[DW-2], flags[`SDX_FLG_L]);
                        end
                        `SDX_CHG_INC: begin
                            next_acc   = acc + DW'(1);
                            next_flags = make_flags(next_acc, acc == {1'b0, {(DW-1){1'b1}}}, flags[`SDX_FLG_L]);
                        end
                        `SDX_CHG_DEC: begin
                            next_acc   = acc - DW'(1);
                            next_flags = make_flags(next_acc, acc == {1'b1, {(DW-1){1'b0}}}, flags[`SDX_FLG_L]);
                        end
                        `SDX_CHG_NEG: begin
                            next_acc   = DW'(0) - acc;
                            next_flags = make_flags(next_acc, acc == {1'b1, {(DW-1){1'b0}}}, flags[`SDX_FLG_L]);
                        end
                        default: begin
                            next_acc   = acc[DW-1] ? DW'(0) - acc : acc;
                            next_flags = make_flags(next_acc, acc == {1'b1, {(DW-1){1'b0}}}, flags[`SDX_FLG_L]);
                        end
                    endcase
                end
                default: acc_we = 1'b0; // flags untouched
            endcase
        end
    end

    // Accumulator register
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst)
            acc <= DW'(`SDX_ACC_RST);
        else if (acc_we)
            acc <= next_acc;
    end

    // Flag register
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst)
            flags <= `SDX_FLAGS_RST;
        else if (flags_we)
            flags <= next_flags;
    end

    // Multiplier operands reload after the product is used
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            mul_a <= '0;
            mul_b <= '0;
        end else if (mul_we) begin
            mul_a <= ram0_rdata;
            mul_b <= ram1_rdata;
        end
    end

    // Analog output register, no read path back
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            dac_data <= '0;
            dac_wr   <= 1'b0;
        end else begin
            dac_wr <= run && cls == SDX_CLS_DAC;
            if (run && cls == SDX_CLS_DAC)
                dac_data <= acc;
        end
    end

    // Pulse for a refused encoding
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst)
            illegal_op <= 1'b0;
        else
            illegal_op <= instr_valid & ~legal;
    end

endmodule // sdx_dsp_exec

// file: dv/sdx_exec_props.sv
`timescale 1ns/1ps
// Port-level checks of the execute block
module sdx_exec_props #(
    parameter int DW = 16,
    parameter int AW = 8
) (
    // Clock and reset
    input wire logic          clk_sys,
    input wire logic          nrst,
    // Instruction and converter side
    input wire logic          instr_valid,
    input wire logic [7:0]    instr_byte,
    input wire logic [DW-1:0] adc_result,
    input wire logic [DW-1:0] dac_data,
    input wire logic          dac_wr,
    // Data RAM side
    input wire logic [AW-1:0] ram0_addr,
    input wire logic [DW-1:0] ram0_rdata,
    input wire logic          ram0_we,
    input wire logic [DW-1:0] ram0_wdata,
    input wire logic [DW-1:0] ram1_rdata,
    input wire logic          ram1_we,
    input wire logic [DW-1:0] ram1_wdata,
    // Datapath state
    input wire logic [DW-1:0] acc,
    input wire logic [3:0]    flags,
    input wire logic [DW-1:0] mul_a,
    input wire logic [DW-1:0] mul_b,
    input wire logic [AW-1:0] ram0_ptr_b,
    input wire logic          illegal_op
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // Decoded instruction groups
    wire [7:0]    b     = instr_byte;
    wire          dacop = instr_valid && b == 8'he0;
    wire          ldop  = instr_valid && b[7:4] == 4'h8 && b[1:0] == 2'h0;
    wire          stop  = instr_valid && b[7:4] == 4'h9 && b[1:0] != 2'h3;
    wire [DW-1:0] rsel  = b[3] ? ram1_rdata : ram0_rdata;

    a_dac_copy: assert property (dacop |=> dac_wr && dac_data == $past(acc) && $stable(flags))
        else $error("analog output copy wrong");
    a_dac_hold: assert property (!dacop |=> !dac_wr && $stable(dac_data))
        else $error("analog output changed");
    a_ld_write: assert property (ldop |-> (b[3] ? ram1_we && ram1_wdata == adc_result
                                                : ram0_we && ram0_wdata == adc_result))
        else $error("converter load write wrong");
    a_st_write: assert property (stop |-> (b[3] ? ram1_we && ram1_wdata == acc : ram0_we && ram0_wdata == acc))
        else $error("store write wrong");
    a_st_addr: assert property (stop && b[3:2] == 2'h1 |-> ram0_addr == ram0_ptr_b)
        else $error("store address wrong");
    a_mem_flags: assert property (stop || ldop |=> $stable(flags) && $stable(acc))
        else $error("memory write changed state");
    a_st_illegal: assert property (instr_valid && b[7:4] == 4'h9 && b[1:0] == 2'h3
                                   |-> !ram0_we && !ram1_we ##1 illegal_op && $stable(acc))
        else $error("illegal store not refused");
    a_add_sum: assert property (instr_valid && b[7:4] == 4'ha |=> acc == $past(acc) + $past(rsel))
        else $error("add result wrong");
    a_mld_load: assert property (instr_valid && b[7:5] == 3'h6
                                 |=> acc == '0 && mul_a == $past(ram0_rdata) && mul_b == $past(ram1_rdata))
        else $error("preload wrong");
    a_mod_false: assert property (instr_valid && b[7:3] == 5'h1e && !flags[3]
                                  |=> $stable(acc) && $stable(flags) && !illegal_op)
        else $error("false condition acted");
    c_ld: cover property (ldop);
    c_mod: cover property (instr_valid && b[7:5] == 3'h7 && b[4:3] != 2'h0);
    c_ill: cover property (illegal_op);
endmodule // sdx_exec_props

bind sdx_dsp_exec sdx_exec_props #(.DW(DW), .AW(AW)) i_sdx_exec_props (.*);

// file: dv/sdx_ram_model.sv
`timescale 1ns/1ps
// Two data RAM banks, read at once, written at the edge
module sdx_ram_model #(
    parameter int DW = 16,
    parameter int AW = 8
) (
    // Clock
    input  wire logic          clk_sys,
    // Bank 0
    input  wire logic [AW-1:0] ram0_addr,
    input  wire logic          ram0_we,
    input  wire logic [DW-1:0] ram0_wdata,
    output logic      [DW-1:0] ram0_rdata,
    // Bank 1
    input  wire logic [AW-1:0] ram1_addr,
    input  wire logic          ram1_we,
    input  wire logic [DW-1:0] ram1_wdata,
    output logic      [DW-1:0] ram1_rdata
);
    // Separate storage per bank
    logic [DW-1:0] mem0 [2**AW];
    logic [DW-1:0] mem1 [2**AW];
    // Non-zero fill so a missed write shows
    initial begin
        for (int i = 0; i < 2**AW; i++) begin
            mem0[i] = DW'(16'ha500 + i);
            mem1[i] = DW'(16'h5a00 + i);
        end
    end
    // Combinational read
    assign ram0_rdata = mem0[ram0_addr];
    assign ram1_rdata = mem1[ram1_addr];
    // Writes land at the edge
    always @(posedge clk_sys) begin
        if (ram0_we) begin
            mem0[ram0_addr] <= ram0_wdata;
        end
        if (ram1_we) begin
            mem1[ram1_addr] <= ram1_wdata;
        end
    end
endmodule // sdx_ram_model

// file: dv/tb.sv
`timescale 1ns/1ps
// Directed instruction sequences for the execute block
module tb;
    // Stimulus
    logic        clk_sys = 1'b0, nrst = 1'b0, instr_valid = 1'b0, ptr_load = 1'b0;
    logic [7:0]  instr_byte = 8'h00, ptr_load_value = 8'h00;
    logic [1:0]  ptr_load_sel = 2'h0;
    logic [7:0]  ram0_loop_mask = 8'hff, ram1_loop_mask = 8'hff;
    logic [15:0] adc_result = 16'h0000;
    // Observed
    logic [15:0] dac_data, ram0_wdata, ram1_wdata, ram0_rdata, ram1_rdata, acc, mul_a, mul_b;
    logic [7:0]  ram0_addr, ram1_addr, ram0_ptr_a, ram0_ptr_b, ram1_ptr_a, ram1_ptr_b;
    logic [3:0]  flags;
    logic        dac_wr, ram0_we, ram1_we, illegal_op;
    int          fails = 0, n_compared = 0, cycles = 0;
    // Expected results of the eight changes on 8001
    logic [15:0] mod_acc [8] = '{16'h4000, 16'h0002, 16'hc000, 16'h0002,
                                16'h8002, 16'h8000, 16'h7fff, 16'h7fff};
    logic [3:0]  mod_flg [8] = '{4'h4, 4'h4, 4'h1, 4'h8, 4'h1, 4'h1, 4'h0, 4'h0};

    sdx_dsp_exec i_sdx_dsp_exec (.*);
    sdx_ram_model i_sdx_ram_model (.*);

    // Clock and hang guard
    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fails++;
            conclude();
        end
    end

    task automatic chk(input string name, input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    // One instruction, sampled after its edge
    task automatic exec(input logic [7:0] op);
        @(posedge clk_sys);
        instr_valid <= 1'b1;
        instr_byte  <= op;
        @(posedge clk_sys);
        instr_valid <= 1'b0;
        #1;
    endtask
    task automatic ptrset(input logic [1:0] sel, input logic [7:0] val);
        @(posedge clk_sys);
        ptr_load       <= 1'b1;
        ptr_load_sel   <= sel;
        ptr_load_value <= val;
        @(posedge clk_sys);
        ptr_load <= 1'b0;
    endtask
    // Converter word into RAM at pointer sel
    task automatic putw(input logic [1:0] sel, input logic [15:0] val);
        @(posedge clk_sys);
        adc_result <= val;
        exec({4'h8, sel, 2'h0});
    endtask
    task automatic setacc(input logic [15:0] val);
        ptrset(2'h0, 8'h00);
        putw(2'h0, val);
        exec(8'hc0);
        exec(8'ha0);
    endtask
    task automatic conclude();
        $display("compared %0d, wrong %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge clk_sys);
        nrst <= 1'b1;
        #1;
        chk("acc", acc, 16'h0000);
        chk("ptrs", {ram0_ptr_a, ram1_ptr_b}, 16'h0000);
        $display("test reset done");
        setacc(16'h1234);
        chk("acc", acc, 16'h1234);
        exec(8'he0);
        chk("dac_data", dac_data, 16'h1234);
        chk("dac_wr", dac_wr, 1'b1);
        ptrset(2'h1, 8'h05);
        exec(8'h95);
        chk("ram0 word", i_sdx_ram_model.mem0[5], 16'h1234);
        chk("ram0_ptr_b", ram0_ptr_b, 16'h0006);
        exec(8'h97);
        chk("illegal_op", illegal_op, 1'b1);
        chk("ram0_ptr_b", ram0_ptr_b, 16'h0006);
        exec(8'h9a);
        chk("ram1 word", i_sdx_ram_model.mem1[1], 16'h1234);
        chk("ram1_ptr_a", ram1_ptr_a, 16'h0000);
        @(posedge clk_sys);
        ram1_loop_mask <= 8'h0f;
        ptrset(2'h2, 8'h10);
        exec(8'hba);
        chk("ram1_ptr_a", ram1_ptr_a, 16'h001f);
        exec(8'hbb);
        chk("ram1_ptr_a", ram1_ptr_a, 16'h0010);
        $display("test memory done");
        setacc(16'h7fff);
        putw(2'h0, 16'h0001);
        exec(8'ha0);
        chk("acc", acc, 16'h8000);
        chk("flags", flags, 4'h9);
        exec(8'hf4);
        chk("acc", acc, 16'h8001);
        chk("flags", flags, 4'h1);
        exec(8'hf4);
        chk("acc", acc, 16'h8001);
        exec(8'he3);
        chk("illegal_op", illegal_op, 1'b1);
        setacc(16'h8000);
        putw(2'h0, 16'h0001);
        exec(8'hb0);
        chk("acc", acc, 16'h7fff);
        chk("flags", flags, 4'h8);
        exec(8'hfe);
        chk("acc", acc, 16'h7fff);
        for (int op = 0; op < 8; op++) begin
            setacc(16'h8001);
            exec(8'he8 | 8'(op));
            chk("mod acc", acc, mod_acc[op]);
            chk("mod flags", flags, mod_flg[op]);
        end
        $display("test flags done");
        ptrset(2'h0, 8'h20);
        ptrset(2'h3, 8'h30);
        putw(2'h0, 16'h4000);
        putw(2'h3, 16'h2000);
        exec(8'hcb);
        chk("mul_a", mul_a, 16'h4000);
        chk("mul_b", mul_b, 16'h2000);
        chk("acc", acc, 16'h0000);
        chk("ptrs", {ram0_ptr_a, ram1_ptr_b}, 16'h2131);
        ptrset(2'h0, 8'h20);
        ptrset(2'h3, 8'h30);
        exec(8'h39);
        chk("acc", acc, 16'h1000);
        chk("mul_b", mul_b, 16'h2000);
        chk("ptrs", {ram0_ptr_a, ram1_ptr_b}, 16'h2131);
        ptrset(2'h0, 8'h20);
        ptrset(2'h3, 8'h30);
        exec(8'h60);
        chk("acc", acc, 16'h0000);
        chk("flags", flags, 4'h2);
        $display("test multiply done");
        conclude();
    end
endmodule // tb
